// >>> verilog/ssms_pkg.sv
package ssms_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [9:0] IDX_ILLUM_MASK   = 10'h09C;
    localparam logic [9:0] IDX_CALC_MASK    = 10'h09D;
    localparam logic [9:0] IDX_PDN_MASK     = 10'h09E;
    localparam logic [9:0] IDX_FRAME_COUNTS = 10'h09F;
    localparam logic [9:0] IDX_CAPTURE_POS  = 10'h0A0;
    localparam logic [9:0] IDX_SUBFRAME_CLK = 10'h0C0;
    localparam logic [9:0] IDX_SEQ_CONTROL  = 10'h0C1;
    localparam logic [9:0] IDX_SEQ_STATUS   = 10'h0C2;

    // bus geometry
    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 32;
    localparam int POS_W      = 12;
    localparam int CNT_W      = 16;

    // field positions
    localparam int END_LSB    = 12;
    localparam int START_LSB  = 0;
    localparam int AVG_LSB    = 12;
    localparam int FLEN_LSB   = 0;
    localparam int CAP_LSB    = 0;
    localparam int AUTO_DIS_BIT = 0;

    // values after reset
    localparam logic [POS_W-1:0] ILLUM_END_RST   = 12'hFFF;
    localparam logic [POS_W-1:0] POS_ZERO_RST    = 12'h000;
    localparam logic [CNT_W-1:0] CAPTURE_POS_RST = 16'h2198;
    localparam logic             AUTO_DIS_RST    = 1'b1;

    // time base: sequencer clock period and nominal sub-frame time
    localparam int CORE_CLK_PERIOD_NS = 8;
    localparam int TG_CLK_PERIOD_NS   = 25;
    localparam int SUBFRAME_TIME_NS   = 250000;
    localparam int SUBFRAME_CLK_CNT   = SUBFRAME_TIME_NS / TG_CLK_PERIOD_NS;
    localparam int PHASE_W            = 6;

    // avalon response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // one sub-frame window: start and end positions
    typedef struct packed {
        logic [POS_W-1:0] end_pos;
        logic [POS_W-1:0] start_pos;
    } ssms_window_t;

    // frame shape
    typedef struct packed {
        logic [POS_W-1:0] averaged_subframe_count;
        logic [POS_W-1:0] frame_length;
    } ssms_frame_t;

    // gated sequencer signals
    typedef struct packed {
        logic illum_enable;
        logic calc_enable;
        logic powerdown_enable;
    } ssms_gate_t;

endpackage

// >>> verilog/ssms_sequencer.sv
// How it works
// R1: the illumination mask end position sits in bits 23:12 and resets to FFFh.
// R2: the illumination mask start position sits in bits 11:0, resets to zero, and illumination is allowed from start through end.
// R3: the calculation mask end position sits in bits 23:12 and resets to zero.
// R4: the calculation mask start position sits in bits 11:0, resets to zero, and calculation is allowed from start through end.
// R5: the power-down mask end position sits in bits 23:12 and resets to zero.
// R6: power-down is allowed only in sub-frames outside the start-through-end range.
// R7: with automatic configuration off, software sets the mask ends and calculation start equal to the averaged count.
// R8: the frame averages the averaged-count field plus one sub-frames; the field resets to zero.
// R9: a frame holds the frame-length field plus one sub-frames; the field resets to zero.
// R10: software keeps the frame length at or above the averaged count.
// R11: a sub-frame lasts the sub-frame clock count times 25 ns.
// R12: data capture happens at the capture count in sequencer clocks within each sub-frame, reset 2198h.
// R13: capture register bits 23:16 read zero and are written as zero.
// R14: a sub-frame counter restarts at zero each frame, steps at each sub-frame boundary, and is compared to the masks.
module ssms_sequencer #(
    parameter logic [ssms_pkg::CNT_W-1:0] SUBFRAME_CLK_RST = ssms_pkg::CNT_W'(ssms_pkg::SUBFRAME_CLK_CNT)
) (
    input  wire logic                          core_clk,        // 125 MHz system clock
    input  wire logic                          resetn,          // synchronous reset, active low
    input  wire logic [ssms_pkg::ADDR_W-1:0]   address,         // avalon byte address
    input  wire logic                          read,            // avalon read request
    input  wire logic                          write,           // avalon write request
    input  wire logic [ssms_pkg::DATA_W-1:0]   writedata,       // avalon write data
    input  wire logic [3:0]                    byteenable,      // avalon byte lanes
    output logic      [ssms_pkg::DATA_W-1:0]   readdata,        // avalon read data
    output logic      [1:0]                    response,        // avalon response code
    output logic                               waitrequest,     // avalon stall
    input  ssms_pkg::ssms_gate_t               raw_signals,     // ungated sequencer signals
    output ssms_pkg::ssms_gate_t               gated_signals,   // signals after sub-frame masks
    output ssms_pkg::ssms_gate_t               mask_open,       // mask windows alone
    output logic                               capture_strobe,  // one-cycle data capture pulse
    output logic                               subframe_start,  // one-cycle pulse at sub-frame boundary
    output logic                               frame_start,     // one-cycle pulse at frame boundary
    output logic                               averaging_active,// sub-frame lies in averaged part
    output logic      [ssms_pkg::POS_W-1:0]    subframe_index   // current sub-frame in frame
);
    import ssms_pkg::*;

    // returns true when pos lies in [lo, hi]
    function automatic logic in_window(input logic [POS_W-1:0] pos, input ssms_window_t win);
        in_window = (pos >= win.start_pos) && (pos <= win.end_pos);
    endfunction

    // merges a write into a stored word under the byte enables
    function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_word,
                                                      input logic [DATA_W-1:0] new_word,
                                                      input logic [3:0]        lanes);
        logic [DATA_W-1:0] result;
        result = old_word;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                result[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        merge_bytes = result;
    endfunction

    ssms_window_t                illum_mask_reg;
    ssms_window_t                calc_mask_reg;
    ssms_window_t                pdn_mask_reg;
    ssms_frame_t                 frame_counts_reg;
    logic [CNT_W-1:0]            capture_pos_reg;
    logic [CNT_W-1:0]            subframe_clk_reg;
    logic                        auto_config_disable_reg;
    logic                        ack_reg;
    logic [DATA_W-1:0]           readdata_reg;
    logic [1:0]                  response_reg;
    logic [PHASE_W-1:0]          phase_reg;
    logic [PHASE_W-1:0]          phase_next;
    logic                        tg_tick;
    logic [CNT_W-1:0]            tg_count_reg;
    logic [POS_W-1:0]            subframe_reg;
    logic                        capture_reg;
    logic                        subframe_start_reg;
    logic                        frame_start_reg;
    ssms_gate_t                  mask_reg;
    ssms_gate_t                  gated_reg;
    logic                        avg_reg;
    logic [9:0]                  word_index;
    logic                        addr_hit;
    logic                        access;
    logic                        write_commit;
    logic [DATA_W-1:0]           read_word;
    logic [DATA_W-1:0]           old_word;
    logic [DATA_W-1:0]           new_word;
    logic [CNT_W-1:0]            period_last;
    logic                        boundary;
    ssms_window_t                illum_eff;
    ssms_window_t                calc_eff;
    ssms_window_t                pdn_eff;
    logic [POS_W-1:0]            next_subframe;

    // address decode: word aligned, known index
    assign word_index = address[ADDR_W-1:2];
    assign access     = read | write;
    always_comb begin
        unique case (word_index)
            IDX_ILLUM_MASK, IDX_CALC_MASK, IDX_PDN_MASK, IDX_FRAME_COUNTS,
            IDX_CAPTURE_POS, IDX_SUBFRAME_CLK, IDX_SEQ_CONTROL, IDX_SEQ_STATUS:
                addr_hit = (address[1:0] == 2'h0);
            default:
                addr_hit = 1'b0;
        endcase
    end

    // one wait cycle on every access; the answer lands on the second edge
    assign waitrequest  = access & ~ack_reg;
    assign write_commit = write & ack_reg & addr_hit;
    assign readdata     = readdata_reg;
    assign response     = response_reg;

    // register read mux; reserved bits read zero
    always_comb begin
        read_word = '0;
        unique case (word_index)
            IDX_ILLUM_MASK:   read_word[23:0] = illum_mask_reg;          // [R1] [R2]
            IDX_CALC_MASK:    read_word[23:0] = calc_mask_reg;           // [R3] [R4]
            IDX_PDN_MASK:     read_word[23:0] = pdn_mask_reg;            // [R5]
            IDX_FRAME_COUNTS: read_word[23:0] = frame_counts_reg;        // [R8] [R9]
            IDX_CAPTURE_POS:  read_word[CNT_W-1:0] = capture_pos_reg;    // [R13]
            IDX_SUBFRAME_CLK: read_word[CNT_W-1:0] = subframe_clk_reg;
            IDX_SEQ_CONTROL:  read_word[AUTO_DIS_BIT] = auto_config_disable_reg;
            IDX_SEQ_STATUS:   read_word[POS_W-1:0] = subframe_reg;
            default:          read_word = '0;
        endcase
        if (!addr_hit) begin
            read_word = '0;
        end
    end

    // write data merged into the current word under the byte lanes
    assign old_word = read_word;
    assign new_word = merge_bytes(old_word, writedata, byteenable);

    // bus handshake and registered answer
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ack_reg      <= 1'b0;
            readdata_reg <= '0;
            response_reg <= RESP_OKAY;
        end else begin
            ack_reg      <= access & ~ack_reg;
            readdata_reg <= (read & ~ack_reg) ? read_word : '0;
            response_reg <= (access & ~ack_reg & ~addr_hit) ? RESP_DECERR : RESP_OKAY;
        end
    end

    // mask window registers
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            illum_mask_reg <= '{end_pos: ILLUM_END_RST, start_pos: POS_ZERO_RST};  // [R1] [R2]
            calc_mask_reg  <= '{end_pos: POS_ZERO_RST, start_pos: POS_ZERO_RST};   // [R3] [R4]
            pdn_mask_reg   <= '{end_pos: POS_ZERO_RST, start_pos: POS_ZERO_RST};   // [R5] [R6]
        end else if (write_commit) begin
            unique case (word_index)
                IDX_ILLUM_MASK: illum_mask_reg <= new_word[23:0];                  // [R1] [R2]
                IDX_CALC_MASK:  calc_mask_reg  <= new_word[23:0];                  // [R3] [R4]
                IDX_PDN_MASK:   pdn_mask_reg   <= new_word[23:0];                  // [R5] [R6]
                default: ;
            endcase
        end
    end

    // frame shape, capture position, sub-frame length and control
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            frame_counts_reg        <= '{averaged_subframe_count: POS_ZERO_RST,
                                         frame_length: POS_ZERO_RST};             // [R8] [R9]
            capture_pos_reg         <= CAPTURE_POS_RST;                           // [R12]
            subframe_clk_reg        <= SUBFRAME_CLK_RST;                          // [R11]
            auto_config_disable_reg <= AUTO_DIS_RST;
        end else if (write_commit) begin
            unique case (word_index)
                IDX_FRAME_COUNTS: frame_counts_reg <= new_word[23:0];             // [R8] [R9]
                IDX_CAPTURE_POS:  capture_pos_reg  <= new_word[CNT_W-1:0];        // [R12] [R13]
                IDX_SUBFRAME_CLK: subframe_clk_reg <= new_word[CNT_W-1:0];        // [R11]
                IDX_SEQ_CONTROL:  auto_config_disable_reg <= new_word[AUTO_DIS_BIT];
                default: ;
            endcase
        end
    end

    // sequencer clock: 25 ns ticks from the 8 ns core clock by phase accumulation
    always_comb begin
        tg_tick    = (phase_reg + PHASE_W'(CORE_CLK_PERIOD_NS)) >= PHASE_W'(TG_CLK_PERIOD_NS);
        phase_next = tg_tick ? PHASE_W'(phase_reg + PHASE_W'(CORE_CLK_PERIOD_NS) - PHASE_W'(TG_CLK_PERIOD_NS))
                             : PHASE_W'(phase_reg + PHASE_W'(CORE_CLK_PERIOD_NS));
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_next;                                              // [R11]
        end
    end

    // a zero clock count still gives one sequencer clock per sub-frame
    assign period_last = (subframe_clk_reg == '0) ? '0 : CNT_W'(subframe_clk_reg - CNT_W'(1));
    assign boundary    = tg_tick && (tg_count_reg == period_last);
    assign next_subframe = (subframe_reg >= frame_counts_reg.frame_length) ? '0
                         : POS_W'(subframe_reg + POS_W'(1));

    // clock count inside the sub-frame
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tg_count_reg <= '0;
        end else if (boundary) begin
            tg_count_reg <= '0;                                                   // [R11]
        end else if (tg_tick) begin
            tg_count_reg <= CNT_W'(tg_count_reg + CNT_W'(1));
        end
    end

    // sub-frame counter wraps after frame length plus one sub-frames
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            subframe_reg       <= '0;
            subframe_start_reg <= 1'b0;
            frame_start_reg    <= 1'b0;
        end else begin
            subframe_start_reg <= boundary;
            frame_start_reg    <= boundary && (next_subframe == '0);              // [R9] [R14]
            if (boundary) begin
                subframe_reg <= next_subframe;                                    // [R9] [R14]
            end
        end
    end

    // capture pulse at the programmed clock inside each sub-frame
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            capture_reg <= 1'b0;
        end else begin
            capture_reg <= tg_tick && (tg_count_reg == capture_pos_reg);          // [R12]
        end
    end

    // effective windows: automatic configuration derives the three end positions and the calc start from the averaged count
    always_comb begin
        illum_eff = illum_mask_reg;
        calc_eff  = calc_mask_reg;
        pdn_eff   = pdn_mask_reg;
        if (!auto_config_disable_reg) begin
            illum_eff.end_pos = frame_counts_reg.averaged_subframe_count;
            calc_eff.end_pos  = frame_counts_reg.averaged_subframe_count;
            calc_eff.start_pos = frame_counts_reg.averaged_subframe_count;
            pdn_eff.end_pos   = frame_counts_reg.averaged_subframe_count;
        end
    end

    // mask evaluation against the sub-frame counter
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mask_reg  <= '0;
            gated_reg <= '0;
            avg_reg   <= 1'b0;
        end else begin
            mask_reg.illum_enable     <= in_window(subframe_reg, illum_eff);      // [R2] [R14]
            mask_reg.calc_enable      <= in_window(subframe_reg, calc_eff);       // [R4] [R14]
            mask_reg.powerdown_enable <= ~in_window(subframe_reg, pdn_eff);       // [R6] [R14]
            gated_reg.illum_enable     <= raw_signals.illum_enable & in_window(subframe_reg, illum_eff);
            gated_reg.calc_enable      <= raw_signals.calc_enable & in_window(subframe_reg, calc_eff);
            gated_reg.powerdown_enable <= raw_signals.powerdown_enable & ~in_window(subframe_reg, pdn_eff);
            avg_reg <= subframe_reg <= frame_counts_reg.averaged_subframe_count;  // [R8]
        end
    end

    // outputs straight from flip-flops
    assign gated_signals    = gated_reg;
    assign mask_open        = mask_reg;
    assign capture_strobe   = capture_reg;
    assign subframe_start   = subframe_start_reg;
    assign frame_start      = frame_start_reg;
    assign averaging_active = avg_reg;
    assign subframe_index   = subframe_reg;

endmodule

// >>> verification/ssms_sequencer_props.sv
// concurrent checks on the register bus and sub-frame outputs
module ssms_sequencer_props
    import ssms_pkg::*;
#(
    parameter logic [ssms_pkg::CNT_W-1:0] SUBFRAME_CLK_RST = 16'h0004  // sub-frame length in ticks
) (
    input wire logic                          core_clk,         // clock
    input wire logic                          resetn,           // reset, active low
    input wire logic [ssms_pkg::ADDR_W-1:0]   address,          // byte address
    input wire logic                          read,             // read request
    input wire logic                          write,            // write request
    input wire logic [ssms_pkg::DATA_W-1:0]   writedata,        // write data
    input wire logic [3:0]                    byteenable,       // byte lanes
    input wire logic [ssms_pkg::DATA_W-1:0]   readdata,         // read data
    input wire logic [1:0]                    response,         // response code
    input wire logic                          waitrequest,      // stall
    input wire ssms_pkg::ssms_gate_t          raw_signals,      // ungated signals
    input wire ssms_pkg::ssms_gate_t          gated_signals,    // masked signals
    input wire ssms_pkg::ssms_gate_t          mask_open,        // windows alone
    input wire logic                          capture_strobe,   // capture pulse
    input wire logic                          subframe_start,   // sub-frame pulse
    input wire logic                          frame_start,      // frame pulse
    input wire logic                          averaging_active, // averaged part
    input wire logic [ssms_pkg::POS_W-1:0]    subframe_index    // sub-frame counter
);
    // one clock domain, reset disables every check
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_wait_first: assert property ((read || write) && !$past(read || write) |-> waitrequest)
        else $error("new request not stalled");
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("request stalled over one cycle");
    a_decode_err: assert property (read && !waitrequest && address == 12'h000 |-> response == RESP_DECERR)
        else $error("unmapped read not refused");
    a_capture_reserved: assert property (read && !waitrequest && address == 12'h280 |->
        response == RESP_OKAY && readdata[31:16] == 16'h0000) else $error("capture upper bits not zero");
    a_sf_pulse: assert property (subframe_start |=> !subframe_start)
        else $error("sub-frame pulse too long");
    a_frame_wrap: assert property (frame_start |-> subframe_start && subframe_index == 12'h000)
        else $error("frame start without index zero");
    a_index_step: assert property (subframe_start && !frame_start |->
        subframe_index == $past(subframe_index) + 12'h001) else $error("index did not step by one");
    a_index_hold: assert property (!subframe_start |-> $stable(subframe_index))
        else $error("index moved inside sub-frame");
    a_capture_once: assert property (capture_strobe |=> !capture_strobe)
        else $error("capture pulse too long");
    a_illum_gate: assert property (gated_signals.illum_enable |-> $past(raw_signals.illum_enable))
        else $error("illumination passed without request");
    a_avg_first: assert property (frame_start |=> averaging_active)
        else $error("first sub-frame not averaged");

    // main scenarios reached
    c_frame: cover property (frame_start);
    c_capture: cover property (capture_strobe);
    c_write: cover property (write && !waitrequest);
    c_read: cover property (read && !waitrequest);
endmodule

bind ssms_sequencer ssms_sequencer_props #(.SUBFRAME_CLK_RST(SUBFRAME_CLK_RST)) u_props (
    .core_clk, .resetn, .address, .read, .write, .writedata, .byteenable, .readdata, .response,
    .waitrequest, .raw_signals, .gated_signals, .mask_open, .capture_strobe, .subframe_start,
    .frame_start, .averaging_active, .subframe_index);

// >>> verification/subframe_signal_mask_sequencer_test.sv
// register and frame-sequencing bench for the sub-frame mask sequencer
module subframe_signal_mask_sequencer_test
    import ssms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                core_clk, resetn, read, write, capture_strobe;
    logic                subframe_start, frame_start, averaging_active, waitrequest;
    logic [ADDR_W-1:0]   address;
    logic [DATA_W-1:0]   writedata, readdata;
    logic [3:0]          byteenable;
    logic [1:0]          response;
    logic [POS_W-1:0]    subframe_index;
    ssms_gate_t          raw_signals, gated_signals, mask_open;
    int                  n_fail, checks_done, n, caps, k, i;

    // short sub-frame so frames pass quickly
    ssms_sequencer #(.SUBFRAME_CLK_RST(16'h0004)) dut (
        .core_clk, .resetn, .address, .read, .write, .writedata, .byteenable, .readdata, .response,
        .waitrequest, .raw_signals, .gated_signals, .mask_open, .capture_strobe, .subframe_start,
        .frame_start, .averaging_active, .subframe_index);

    // 125 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // closing report and verdict
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // compare one value
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one avalon access; held until waitrequest is seen low
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
             output logic [1:0] rs);
        int w;
        @(posedge core_clk);
        address <= a;
        writedata <= wd;
        read <= !wr;
        write <= wr;
        w = 0;
        // sample waitrequest and the answer at the rising edge itself
        do begin
            @(posedge core_clk);
            w++;
        end while (waitrequest !== 1'b0 && w < 50);
        rd = readdata;
        rs = response;
        read <= 1'b0;
        write <= 1'b0;
        if (w >= 50) begin
            chk("waitrequest", 32'h0, 32'(waitrequest));
            tally_and_finish();
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic [1:0]  r;
        bus(1'b1, a, d, x, r);
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] rexp);
        logic [31:0] x;
        logic [1:0]  r;
        bus(1'b0, a, 32'h0, x, r);
        chk("readdata", exp, x);
        chk("response", {30'h0, rexp}, {30'h0, r});
    endtask

    // count cycles and captures up to the next sub-frame pulse
    task wait_sf;
        do begin
            @(negedge core_clk);
            n++;
            caps += 32'(capture_strobe);
        end while (subframe_start !== 1'b1 && n < 100);
        if (n >= 100) begin
            chk("subframe_start", 32'h1, 32'(subframe_start));
            tally_and_finish();
        end
    endtask

    initial begin
        n_fail = 0;
        checks_done = 0;
        resetn = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = '0;
        writedata = '0;
        byteenable = 4'hF;
        raw_signals = 3'b111;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;

        // reset values and unmapped access
        rd_chk(12'h270, 32'h00FFF000, RESP_OKAY);
        rd_chk(12'h274, 32'h00000000, RESP_OKAY);
        rd_chk(12'h278, 32'h00000000, RESP_OKAY);
        rd_chk(12'h27C, 32'h00000000, RESP_OKAY);
        rd_chk(12'h280, 32'h00002198, RESP_OKAY);
        rd_chk(12'h300, 32'h00000004, RESP_OKAY);
        rd_chk(12'h000, 32'h00000000, RESP_DECERR);
        $display("test reset values done");

        // field placement and reserved capture bits
        wr(12'h270, 32'h00ABC123);
        rd_chk(12'h270, 32'h00ABC123, RESP_OKAY);
        wr(12'h280, 32'hFFFF1234);
        rd_chk(12'h280, 32'h00001234, RESP_OKAY);
        wr(12'h27C, 32'h00001003);
        wr(12'h270, 32'h00001000);
        wr(12'h274, 32'h00001001);
        wr(12'h278, 32'h00001001);
        wr(12'h280, 32'h00000002);
        rd_chk(12'h27C, 32'h00001003, RESP_OKAY);
        $display("test register access done");

        // align to a frame, then walk two frames of four sub-frames
        k = 0;
        do begin
            n = 0;
            wait_sf();
            k++;
        end while (frame_start !== 1'b1 && k < 12);
        chk("frame align", 32'h1, 32'(frame_start));
        for (k = 0; k < 8; k++) begin
            i = k % 4;
            chk("subframe_index", 32'(i), 32'(subframe_index));
            chk("frame_start", 32'(i == 0), 32'(frame_start));
            n = 0;
            caps = 0;
            repeat (3) begin
                @(negedge core_clk);
                n++;
                caps += 32'(capture_strobe);
            end
            chk("illum window", 32'(i <= 1), 32'(mask_open.illum_enable));
            chk("calc window", 32'(i == 1), 32'(mask_open.calc_enable));
            chk("gated", {29'h0, i <= 1, i == 1, i != 1}, {29'h0, gated_signals});
            chk("averaging", 32'(i <= 1), 32'(averaging_active));
            wait_sf();
            chk("subframe cycles", (n == 13) ? 32'd13 : 32'd12, 32'(n));
            chk("captures", 32'd1, 32'(caps));
        end
        @(posedge core_clk);
        raw_signals <= 3'b000;
        repeat (3) @(negedge core_clk);
        chk("gated idle", 32'h0, {29'h0, gated_signals});

        // automatic configuration takes the calc window from the averaged count
        wr(12'h274, 32'h00000000);
        wr(12'h304, 32'h00000000);
        rd_chk(12'h304, 32'h00000000, RESP_OKAY);
        k = 0;
        do begin
            n = 0;
            wait_sf();
            k++;
        end while (subframe_index !== 12'h001 && k < 12);
        chk("auto align", 32'h1, 32'(subframe_index));
        repeat (3) @(negedge core_clk);
        chk("auto calc window", 32'h1, 32'(mask_open.calc_enable));
        $display("test frame sequencing done");
        tally_and_finish();
    end
endmodule
